// file: verilog/rts_sequencer.v
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "rts_map.vh"

module rts_sequencer (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // Activity of other units
  input wire lfr_active,
  input wire smi_active,
  input wire mcu_active,
  // Timing strobes and loop lock level
  input wire half_bit_tick,
  input wire ms_tick,
  input wire pll_ready,
  // Analog controls and completion interrupt
  output reg medium_freq_oscillator_enable,
  output reg xtal_enable,
  output reg pll_enable,
  output reg pa_enable,
  output reg rf_data,
  output reg completion_irq
);

  // Sequencer states
  localparam ST_IDLE = 3'd0;
  localparam ST_SPACE = 3'd1;
  localparam ST_WARM = 3'd2;
  localparam ST_TX = 3'd3;
  localparam ST_FINISH = 3'd4;
  localparam ST_DIRECT = 3'd5;

  //////////////////////////////////////////////////////////////////////////
  // Control bits
  reg send; // Transmit request
  reg interframe_power_down; // Oscillators off in gaps
  reg transmit_interrupt_enable; // Gates completion interrupt
  reg [1:0] code; // Coding select
  reg polarity_invert; // Direct-mode inversion
  reg data_bit; // Direct-mode data
  reg transmit_complete_flag; // Sticky completion
  reg [7:0] frame_length_field; // Bits per frame minus one
  reg [3:0] frame_num; // Frames per datagram minus one
  reg [7:0] base_time; // Base spacing in ms
  reg [6:0] lfsr; // Random generator state
  reg [5:0] frame_add; // Per-frame spacing adder
  reg timer_en; // Spacing timer in use
  reg init_x40; // Initial random scaled by forty
  reg [7:0] buf_byte [0:31]; // Data buffer storage
  // Sequencer state
  reg [2:0] state; // Current state
  reg [7:0] bit_idx; // Current buffer bit
  reg half; // Second half of bit
  reg bp_level; // Bi-phase line level
  reg [3:0] frames_sent; // Completed frames
  reg first_space; // Spacing before first frame
  reg [15:0] timer; // Spacing countdown in ms
  // Decoded helpers
  wire [255:0] buf_flat; // Buffer as one bit vector
  wire direct_mode; // Coding select is direct
  wire wr_ctrl; // Control write strobe
  wire clr_flag; // Software flag clear
  wire frame_done; // Last half of last bit
  wire cur_bit; // Bit now on air
  wire [15:0] rand_ms; // Random term
  wire [15:0] init_ms; // Initial interval
  wire [15:0] ifrm_ms; // Interframe interval
  wire [4:0] frame_no; // One-based frame just sent
  reg [15:0] next_interval; // Interval to load
  reg enc_bit; // Encoded line level
  wire osc_on; // Crystal and loop wanted

  //////////////////////////////////////////////////////////////////////////
  // Flatten buffer so that byte zero bit zero is index zero
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_buf
      assign buf_flat[gi*8 +: 8] = buf_byte[gi];
      always @(posedge clk) begin
        if (rst) begin
          buf_byte[gi] <= 8'h00;
        end else if (reg_write &&
                     reg_addr == `RTS_ADDR_BUF_FIRST + gi) begin
          buf_byte[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  assign direct_mode = (code == `RTS_CODE_DIRECT);
  assign wr_ctrl = reg_write && reg_addr == `RTS_ADDR_CTRL;
  assign clr_flag = reg_write && reg_addr == `RTS_ADDR_STATUS &&
                    reg_wdata[`RTS_STAT_FLAG];
  // Length field plus one bits, so last index equals the field
  assign frame_done = (state == ST_TX) && half_bit_tick && half &&
                      (bit_idx == frame_length_field);
  assign cur_bit = buf_flat[bit_idx];

  //////////////////////////////////////////////////////////////////////////
  // Spacing arithmetic; a zero LFSR contributes nothing
  assign rand_ms = {9'h000, lfsr};
  assign init_ms = {8'h00, base_time} +
                   (init_x40 ? rand_ms * `RTS_INIT_RAND_MULT : rand_ms);
  assign frame_no = {1'b0, frames_sent} + 5'h01;
  assign ifrm_ms = {8'h00, base_time} + rand_ms +
                   ({11'h000, frame_no} * {10'h000, frame_add});

  // Interval picked at entry to a space; zero when timer unused
  always @* begin
    next_interval = 16'h0000;
    if (timer_en) begin
      next_interval = (state == ST_IDLE) ? init_ms : ifrm_ms;
    end
  end

  // Line encoding of current buffer bit
  always @* begin
    case (code)
      `RTS_CODE_MANCH: enc_bit = half ? cur_bit : ~cur_bit;
      `RTS_CODE_BIPHASE: enc_bit = bp_level;
      `RTS_CODE_NRZ: enc_bit = cur_bit;
      default: enc_bit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Software-visible control registers
  always @(posedge clk) begin
    if (rst) begin
      interframe_power_down <= 1'b0;
      transmit_interrupt_enable <= 1'b0;
      code <= `RTS_CODE_MANCH;
      polarity_invert <= 1'b0;
      data_bit <= 1'b0;
      frame_length_field <= 8'h00;
      frame_num <= 4'h0;
      base_time <= 8'h00;
      frame_add <= 6'h00;
      timer_en <= 1'b0;
      init_x40 <= 1'b0;
    end else if (reg_write) begin
      // Writes mid-datagram take effect at once; software must not
      case (reg_addr)
        `RTS_ADDR_CTRL: begin
          interframe_power_down <= reg_wdata[`RTS_CTRL_PWRDN];
          transmit_interrupt_enable <= reg_wdata[`RTS_CTRL_IE];
          code <= reg_wdata[`RTS_CTRL_CODE_HI:`RTS_CTRL_CODE_LO];
          polarity_invert <= reg_wdata[`RTS_CTRL_INVERT];
          data_bit <= reg_wdata[`RTS_CTRL_DATA];
        end
        `RTS_ADDR_FRAME_LEN: frame_length_field <= reg_wdata;
        `RTS_ADDR_FRAME_NUM: frame_num <= reg_wdata[3:0];
        `RTS_ADDR_BASE_TIME: base_time <= reg_wdata;
        `RTS_ADDR_FRAME_ADD: frame_add <= reg_wdata[5:0];
        `RTS_ADDR_SPACING: begin
          timer_en <= reg_wdata[`RTS_SPC_TIMER_EN];
          init_x40 <= reg_wdata[`RTS_SPC_INIT_X40];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr >= `RTS_ADDR_BUF_FIRST &&
          reg_addr <= `RTS_ADDR_BUF_LAST) begin
        reg_rdata <= buf_byte[reg_addr[4:0] ^ 5'h10]; // Base at byte zero
      end else begin
        case (reg_addr)
          `RTS_ADDR_CTRL: reg_rdata <= {1'b0, data_bit, polarity_invert,
                                        code, transmit_interrupt_enable,
                                        interframe_power_down, send};
          `RTS_ADDR_STATUS: reg_rdata <= {1'b0, state, 2'b00,
                                          pa_enable,
                                          transmit_complete_flag};
          `RTS_ADDR_FRAME_LEN: reg_rdata <= frame_length_field;
          `RTS_ADDR_FRAME_NUM: reg_rdata <= {4'h0, frame_num};
          `RTS_ADDR_BASE_TIME: reg_rdata <= base_time;
          `RTS_ADDR_LFSR: reg_rdata <= {1'b0, lfsr};
          `RTS_ADDR_FRAME_ADD: reg_rdata <= {2'b00, frame_add};
          `RTS_ADDR_SPACING: reg_rdata <= {6'h00, init_x40, timer_en};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit request: software sets, hardware clears at the end
  always @(posedge clk) begin
    if (rst) begin
      send <= 1'b0;
    end else if (wr_ctrl) begin
      send <= reg_wdata[`RTS_CTRL_SEND]; // Software write wins
    end else if (state == ST_FINISH) begin
      send <= 1'b0;
    end
  end

  // Sticky completion flag, set wins over write-one-clear
  always @(posedge clk) begin
    if (rst) begin
      transmit_complete_flag <= 1'b0;
    end else if (state == ST_FINISH) begin
      transmit_complete_flag <= 1'b1;
    end else if (clr_flag) begin
      transmit_complete_flag <= 1'b0;
    end
  end

  // Random generator; advanced once after each use, writable
  always @(posedge clk) begin
    if (rst) begin
      lfsr <= `RTS_LFSR_RESET;
    end else if (reg_write && reg_addr == `RTS_ADDR_LFSR) begin
      lfsr <= reg_wdata[6:0];
    end else if (state == ST_SPACE && timer == 16'h0000 && timer_en) begin
      lfsr <= {1'b0, lfsr[6:1]} ^ (lfsr[0] ? `RTS_LFSR_TAPS : 7'h00);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Datagram sequencer; spacing timer loads on entry to a space
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_idx <= 8'h00;
      half <= 1'b0;
      bp_level <= 1'b0;
      frames_sent <= 4'h0;
      first_space <= 1'b0;
      timer <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          frames_sent <= 4'h0;
          if (send && direct_mode) begin
            state <= ST_DIRECT;
          end else if (send) begin
            state <= ST_SPACE;
            first_space <= 1'b1;
            timer <= next_interval;
          end
        end
        ST_SPACE: begin
          // Timer figure was loaded on entry; count ms ticks
          if (!send) begin
            state <= ST_IDLE;
          end else if (timer == 16'h0000) begin
            state <= ST_WARM;
            first_space <= 1'b0;
          end else if (ms_tick) begin
            timer <= timer - 16'h0001;
          end
        end
        ST_WARM: begin
          if (!send) begin
            state <= ST_IDLE;
          end else if (pll_ready && xtal_enable && half_bit_tick) begin
            // Stale lock ignored while crystal off; start on a tick
            state <= ST_TX;
            bit_idx <= 8'h00;
            half <= 1'b0;
            bp_level <= 1'b1;
          end
        end
        ST_TX: begin
          if (!send) begin
            state <= ST_IDLE;
          end else if (half_bit_tick) begin
            // Crystal-derived ticks pace every half bit
            half <= ~half;
            if (!half) begin
              bp_level <= bp_level ^ cur_bit;
            end else begin
              bp_level <= ~bp_level;
            end
            if (frame_done && frames_sent == frame_num) begin
              state <= ST_FINISH;
            end else if (frame_done) begin
              state <= ST_SPACE;
              frames_sent <= frames_sent + 4'h1;
              timer <= next_interval;
            end else if (half) begin
              bit_idx <= bit_idx + 8'h01;
            end
          end
        end
        ST_FINISH: state <= ST_IDLE;
        ST_DIRECT: begin
          if (!send || !direct_mode) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Oscillators stay up in gaps unless power-down asked for
  assign osc_on = (state == ST_WARM) || (state == ST_TX) ||
                  (state == ST_DIRECT) ||
                  (state == ST_SPACE && !first_space &&
                   !interframe_power_down);
  // Registered enables; clearing send darkens the amplifier at once
  always @(posedge clk) begin
    if (rst) begin
      medium_freq_oscillator_enable <= 1'b0;
      xtal_enable <= 1'b0;
      pll_enable <= 1'b0;
      pa_enable <= 1'b0;
      rf_data <= 1'b0;
      completion_irq <= 1'b0;
    end else begin
      medium_freq_oscillator_enable <= send | lfr_active | smi_active |
                                       mcu_active;
      xtal_enable <= osc_on;
      pll_enable <= osc_on;
      pa_enable <= send && ((state == ST_TX) ||
                   (state == ST_DIRECT && pll_ready));
      if (state == ST_TX) begin
        rf_data <= enc_bit;
      end else if (state == ST_DIRECT && pll_ready && pa_enable) begin
        rf_data <= data_bit ^ polarity_invert;
      end else begin
        rf_data <= 1'b0;
      end
      completion_irq <= transmit_complete_flag &&
                        transmit_interrupt_enable;
    end
  end
endmodule

`default_nettype wire

// file: verilog/rts_map.vh
`ifndef RTS_MAP_VH
`define RTS_MAP_VH

// Register offsets
`define RTS_ADDR_CTRL 8'h00
`define RTS_ADDR_STATUS 8'h01
`define RTS_ADDR_FRAME_LEN 8'h02
`define RTS_ADDR_FRAME_NUM 8'h03
`define RTS_ADDR_BASE_TIME 8'h04
`define RTS_ADDR_LFSR 8'h05
`define RTS_ADDR_FRAME_ADD 8'h06
`define RTS_ADDR_SPACING 8'h07
`define RTS_ADDR_BUF_FIRST 8'h10
`define RTS_ADDR_BUF_LAST 8'h2f

// Control register fields
`define RTS_CTRL_SEND 0
`define RTS_CTRL_PWRDN 1
`define RTS_CTRL_IE 2
`define RTS_CTRL_CODE_LO 3
`define RTS_CTRL_CODE_HI 4
`define RTS_CTRL_INVERT 5
`define RTS_CTRL_DATA 6

// Status register fields
`define RTS_STAT_FLAG 0
`define RTS_STAT_CTS 1

// Spacing register fields
`define RTS_SPC_TIMER_EN 0
`define RTS_SPC_INIT_X40 1

// Coding select values
`define RTS_CODE_MANCH 2'h0
`define RTS_CODE_BIPHASE 2'h1
`define RTS_CODE_NRZ 2'h2
`define RTS_CODE_DIRECT 2'h3

// Random generator reset value and taps, initial random multiplier
`define RTS_LFSR_RESET 7'h40
`define RTS_LFSR_TAPS 7'h60
`define RTS_INIT_RAND_MULT 16'h0028

`endif

// file: test/rts_sequencer_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "rts_map.vh"
module rts_sequencer_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Activity and timing
  input wire logic lfr_active,
  input wire logic smi_active,
  input wire logic mcu_active,
  input wire logic half_bit_tick,
  input wire logic ms_tick,
  input wire logic pll_ready,
  // Analog controls and completion interrupt
  input wire logic medium_freq_oscillator_enable,
  input wire logic xtal_enable,
  input wire logic pll_enable,
  input wire logic pa_enable,
  input wire logic rf_data,
  input wire logic completion_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Enable bit as software last wrote it
  logic ie_copy;
  ////////////////////
  // Same edge as the device register, so irq can be tied to it
  always_ff @(posedge clk) begin
    if (rst) begin
      ie_copy <= 1'b0;
    end else if (reg_write && reg_addr == `RTS_ADDR_CTRL) begin
      ie_copy <= reg_wdata[`RTS_CTRL_IE];
    end
  end
  ////////////////////
  a_osc_follows: assert property (
    (lfr_active || smi_active || mcu_active) |=>
    medium_freq_oscillator_enable) else $error("oscillator enable missing");
  a_pa_osc_on: assert property (
    pa_enable |-> medium_freq_oscillator_enable)
    else $error("amplifier on without clock");
  a_pa_after_lock: assert property (
    pa_enable |-> pll_ready && xtal_enable && pll_enable)
    else $error("amplifier on before lock");
  a_xtal_pll_pair: assert property (
    xtal_enable == pll_enable) else $error("crystal and loop disagree");
  a_rf_idle_low: assert property (
    !pa_enable && !$past(pa_enable) |-> !rf_data)
    else $error("carrier while idle");
  a_irq_needs_ie: assert property (
    completion_irq |-> $past(ie_copy)) else $error("irq while disabled");
  a_irq_holds: assert property (
    completion_irq && !$past(reg_write) |=> completion_irq)
    else $error("irq dropped on its own");
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
endmodule
`default_nettype wire

// file: test/rts_rf_model.sv
`timescale 1ns/1ns
`default_nettype none
module rts_rf_model #(
  parameter int LOCK_CYC = 20,
  parameter int HALF_CYC = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Power controls
  input wire logic xtal_enable,
  input wire logic pll_enable,
  // Loop status and crystal strobe
  output logic pll_ready,
  output logic half_bit_tick
);
  // Settling and divider counts
  int lock_cnt;
  int half_cnt;
  ////////////////////
  // Loop locks only with both powered; divider runs only when locked
  always_ff @(posedge clk) begin
    if (rst || !xtal_enable || !pll_enable) begin
      lock_cnt <= 0;
      half_cnt <= 0;
      pll_ready <= 1'b0;
      half_bit_tick <= 1'b0;
    end else if (lock_cnt < LOCK_CYC) begin
      lock_cnt <= lock_cnt + 1;
      pll_ready <= (lock_cnt == LOCK_CYC - 1);
    end else begin
      half_cnt <= (half_cnt == HALF_CYC - 1) ? 0 : half_cnt + 1;
      half_bit_tick <= (half_cnt == HALF_CYC - 1);
    end
  end
endmodule
`default_nettype wire

// file: test/rts_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rts_map.vh"
module rts_sequencer_tb_top;
  // Bus and unit activity, all driven here
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic lfr_active = 1'b0;
  logic smi_active = 1'b0;
  logic mcu_active = 1'b0;
  logic ms_tick = 1'b0;
  logic [1:0] ms_div = 2'h0;
  // Design and model outputs
  logic [7:0] reg_rdata;
  logic half_bit_tick, pll_ready, medium_freq_oscillator_enable;
  logic xtal_enable, pll_enable, pa_enable, rf_data, completion_irq;
  // Bench state
  int error_cnt = 0;
  int checks_done = 0;
  int fall_cnt, xoff_cnt, exp_fr;
  logic [7:0] bmem [0:31];
  logic halves [$];
  logic pa_q = 1'b0;
  logic [7:0] d;
  always #4 clk = ~clk;
  rts_sequencer dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .lfr_active, .smi_active, .mcu_active,
    .half_bit_tick, .ms_tick, .pll_ready, .medium_freq_oscillator_enable,
    .xtal_enable, .pll_enable, .pa_enable, .rf_data, .completion_irq);
  rts_rf_model #(.LOCK_CYC(20), .HALF_CYC(6)) u_rf (.clk, .rst,
    .xtal_enable, .pll_enable, .pll_ready, .half_bit_tick);
  ////////////////////
  // Millisecond strobe shortened to one in four cycles
  always @(posedge clk) begin
    ms_div <= ms_div + 2'h1;
    ms_tick <= (ms_div == 2'h3);
  end
  // Line capture: level seen at each half tick, frames and dark gaps
  always @(posedge clk) begin
    pa_q <= pa_enable;
    if (half_bit_tick && pa_enable) halves.push_back(rf_data);
    if (pa_q && !pa_enable) fall_cnt++;
    if (fall_cnt > 0 && fall_cnt < exp_fr && !xtal_enable) xoff_cnt++;
  end
  ////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  // One datagram from the buffer, checked half by half
  task automatic run(input logic [1:0] code, input logic [7:0] len,
      input logic [3:0] nm1, input logic pdn, input logic ie,
      input logic [1:0] spc);
    int n, nb, ok;
    logic b, h0, h1, lvl;
    halves.delete();
    fall_cnt = 0;
    xoff_cnt = 0;
    exp_fr = nm1 + 1;
    nb = len + 1;
    wr(`RTS_ADDR_FRAME_LEN, len);
    wr(`RTS_ADDR_FRAME_NUM, {4'h0, nm1});
    wr(`RTS_ADDR_SPACING, {6'h00, spc});
    wr(`RTS_ADDR_CTRL, {3'h0, code, ie, pdn, 1'b1});
    n = 0;
    d = 8'h01;
    while (d[0] !== 1'b0 && n < 20000) begin
      rd(`RTS_ADDR_CTRL, d);
      n++;
    end
    chk(8'(d[0]), 8'h00);
    chk(8'(pa_enable), 8'h00);
    rd(`RTS_ADDR_STATUS, d);
    chk(8'(d[0]), 8'h01);
    repeat (2) @(posedge clk);
    chk(8'(completion_irq), 8'(ie));
    chk(8'(fall_cnt), 8'(exp_fr));
    if (nm1 != 4'h0) chk(8'(xoff_cnt > 0), 8'(pdn));
    chk(8'(halves.size() == 2 * nb * exp_fr), 8'h01);
    ok = (halves.size() == 2 * nb * exp_fr);
    for (int f = 0; f < exp_fr && ok; f++) begin
      lvl = 1'b0;
      for (int k = 0; k < nb; k++) begin
        b = bmem[k / 8][k % 8];
        h0 = (code == `RTS_CODE_MANCH) ? ~b :
          (code == `RTS_CODE_NRZ) ? b : ~lvl;
        h1 = (code == `RTS_CODE_BIPHASE) ? h0 ^ b : b;
        lvl = h1;
        chk(8'(halves[2 * (f * nb + k)]), 8'(h0));
        chk(8'(halves[2 * (f * nb + k) + 1]), 8'(h1));
      end
    end
    wr(`RTS_ADDR_STATUS, 8'h01);
    rd(`RTS_ADDR_STATUS, d);
    chk(8'(d[0]), 8'h00);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////
  // Hang guard, well past the longest datagram
  initial begin
    #(8 * 60000);
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`RTS_ADDR_LFSR, d);
    chk(d, 8'h40);
    rd(8'h3f, d);
    chk(d, 8'h00);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {mcu_active, smi_active, lfr_active} <= 3'h1 << i;
      repeat (3) @(posedge clk);
      chk(8'(medium_freq_oscillator_enable), 8'h01);
    end
    {mcu_active, smi_active, lfr_active} <= 3'h0;
    repeat (3) @(posedge clk);
    chk(8'(medium_freq_oscillator_enable), 8'h00);
    for (int i = 0; i < 32; i++) begin
      bmem[i] = 8'(i * 37 + 5);
      wr(8'(`RTS_ADDR_BUF_FIRST + i), bmem[i]);
    end
    rd(`RTS_ADDR_BUF_FIRST, d);
    chk(d, bmem[0]);
    rd(`RTS_ADDR_BUF_LAST, d);
    chk(d, bmem[31]);
    run(`RTS_CODE_NRZ, 8'd1, 4'hf, 1'b1, 1'b0, 2'h0);
    run(`RTS_CODE_MANCH, 8'd255, 4'h0, 1'b0, 1'b1, 2'h0);
    wr(`RTS_ADDR_BASE_TIME, 8'h02);
    wr(`RTS_ADDR_FRAME_ADD, 8'h01);
    run(`RTS_CODE_BIPHASE, 8'd12, 4'h1, 1'b0, 1'b1, 2'h1);
    rd(`RTS_ADDR_LFSR, d);
    chk(d, 8'h10);
    wr(`RTS_ADDR_CTRL, 8'h19);
    d = 8'h00;
    for (int n = 0; n < 100 && d[1] !== 1'b1; n++) rd(`RTS_ADDR_STATUS, d);
    chk(8'(d[1]), 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(`RTS_ADDR_CTRL, {1'b0, 2'(i), 5'h19});
      repeat (3) @(posedge clk);
      chk(8'(rf_data), 8'(i[0] ^ i[1]));
    end
    wr(`RTS_ADDR_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk({pa_enable, rf_data}, 8'h00);
    give_verdict;
  end
endmodule
bind rts_sequencer rts_sequencer_sva u_sva (.clk, .rst, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .lfr_active, .smi_active,
  .mcu_active, .half_bit_tick, .ms_tick, .pll_ready,
  .medium_freq_oscillator_enable, .xtal_enable, .pll_enable, .pa_enable,
  .rf_data, .completion_irq);
`default_nettype wire
